// ---- inc/calcc_pkg.sv ----
// Purpose: Shared constants and types for the calibration coefficient store and readout
// Assumes: One 100 MHz clock, image held in flip-flops in readout byte order
// Notes: Byte index n holds readout byte n+1
package calcc_pkg;

  // ------------------------------------------------------------
  // Image geometry
  // ------------------------------------------------------------
  localparam int unsigned CALCC_NBYTES = 20;
  localparam logic [4:0] CALCC_LAST_IDX = 5'h13;
  localparam logic [4:0] CALCC_SIG_IDX = 5'h0E;
  localparam logic [4:0] CALCC_PRE_SIG_IDX = 5'h0D;
  localparam logic [4:0] CALCC_POST_SIG_IDX = 5'h0F;
  localparam logic [4:0] CALCC_LAST_SIGNED_IDX = 5'h12;
  localparam logic [7:0] CALCC_TAIL_BYTE = 8'hA5;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam logic [4:0] CALCC_OFS_LO_IDX = 5'h00;
  localparam logic [4:0] CALCC_OFS_HI_IDX = 5'h01;
  localparam logic [4:0] CALCC_SOT_IDX = 5'h07;
  localparam logic [4:0] CALCC_CFG_A_IDX = 5'h08;
  localparam logic [4:0] CALCC_CFG_B_IDX = 5'h09;
  localparam logic [4:0] CALCC_CFG_C_IDX = 5'h0A;
  localparam logic [4:0] CALCC_TRIM_IDX = 5'h0F;
  localparam logic [4:0] CALCC_MODE_IDX = 5'h10;
  localparam logic [4:0] CALCC_GAIN_LO_IDX = 5'h11;
  localparam logic [4:0] CALCC_GAIN_HI_IDX = 5'h12;

  // ------------------------------------------------------------
  // Reset values and write masks, byte 0 in the low bits
  // ------------------------------------------------------------
  localparam logic [159:0] CALCC_RESET_IMAGE = 160'h0000_0000_0000_0000_0001_FC71_0000_0000_0000_0000;
  localparam logic [159:0] CALCC_WRITE_MASK = 160'h00FF_FFFF_FF00_FFFF_FFFF_FFFF_FF00_0000_0000_3FFF;

  // ------------------------------------------------------------
  // Commands, lock codes, signature
  // ------------------------------------------------------------
  localparam logic [7:0] CALCC_CMD_READ = 8'h00;
  localparam logic [2:0] CALCC_LOCK_CODE_A = 3'h3;
  localparam logic [2:0] CALCC_LOCK_CODE_B = 3'h6;
  localparam logic [7:0] CALCC_SIG_POLY = 8'h07;
  localparam logic [7:0] CALCC_SIG_SEED = 8'h00;

  // ------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------
  localparam logic [4:0] CALCC_ADDR_STATUS = 5'h14;
  localparam logic [4:0] CALCC_ADDR_CORR_LO = 5'h15;
  localparam logic [4:0] CALCC_ADDR_CORR_HI = 5'h16;

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  localparam logic [13:0] CALCC_RAW_MAX = 14'h3FFF;
  localparam int unsigned CALCC_GAIN_FRAC = 11;
  localparam int unsigned CALCC_GAIN_SCALE_SH = 3;
  localparam logic [5:0] CALCC_SOT_MULT = 6'h29;
  localparam int unsigned CALCC_SOT_SHIFT = 14;

  typedef enum logic [1:0] {
    CALCC_ST_CHECK = 2'b10,
    CALCC_ST_IDLE = 2'b01,
    CALCC_ST_SEND = 2'b11,
    CALCC_ST_SIGN = 2'b00
  } calcc_state_t;

  typedef struct packed {
    logic [14:0] gain;
    logic [13:0] offset;
    logic [7:0] second_order_coeff;
  } calcc_coeff_t;

  typedef struct packed {
    logic [2:0] lock;
    logic [2:0] diag_cfg;
    logic [3:0] preamp_gain;
    logic [6:0] upper_clip;
    logic [6:0] lower_clip;
    logic [3:0] adc_offset_trim;
    logic [3:0] reference_voltage_trim;
    logic [2:0] osc_trim;
    logic [1:0] regulator_config;
    logic [1:0] update_rate;
    logic [1:0] output_mode;
  } calcc_config_t;

endpackage

// ---- rtl/calcc_sat14.sv ----
// Purpose: Clamp a signed value into the 14-bit unsigned bridge range
// Assumes: Input is two's complement of width W
// Notes: Saturates at both ends, never wraps
`timescale 1ns/100ps
`default_nettype none
module calcc_sat14 #(
  parameter int unsigned W = 24
) (
  input wire logic signed [W-1:0] value,
  output logic [13:0] clamped
);

  // ------------------------------------------------------------
  // Clamp
  // ------------------------------------------------------------
  always_comb begin
    if (value < 0) begin
      clamped = 14'h0000;
    end else if (value > $signed({{(W-14){1'b0}}, calcc_pkg::CALCC_RAW_MAX})) begin
      clamped = calcc_pkg::CALCC_RAW_MAX;
    end else begin
      clamped = value[13:0];
    end
  end

endmodule
`default_nettype wire

// ---- rtl/calcc_top.sv ----
// Purpose: Calibration coefficient store, bridge correction and full-image readout
// Assumes: Link layer delivers command bytes and acknowledges each sent byte
// Notes: Image held as 20 byte flip-flops in readout order
//
// Behaviour
// - Raw bridge value is unsigned, zero to 16383, step one.
// - Gain is 15 bits, range zero to 64; bit 14 multiplies lower part by eight.
// - Gain bits 13:0 are fixed point below eight, bit 13 weighs four.
// - Offset is 14-bit unsigned, top bit weighs 8192, down to one.
// - Second-order term corrects nonlinearity, quarter percent steps, plus/minus 32 percent.
// - Arithmetic saturates instead of wrapping on excessive negative nonlinearity.
// - Read command 00 streams every byte of the calibration image.
// - After each sent byte the image shifts by eight bits.
// - Bytes 1-2 offset, byte 2 top bits reserved, 3-7 reserved, 8 second-order.
// - Bytes 9-11 hold lock, diagnostics, preamp gain and clip limits.
// - Bytes 12-14 customer tags, 15 signature, 16 adc offset and trims.
// - Bytes 17-19 regulator, rate, mode, adc offset, gain; byte 20 constant.
// - Eight-bit shift-register signature computed and checked at power-on.
// - Lock field 011 or 110 blocks every write permanently; here only until arst_n reloads the reset image, whose lock field is 000.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module calcc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_done,
  input wire logic raw_valid,
  input wire logic [13:0] raw_bridge_value,
  output logic corr_valid,
  output logic [13:0] corr_value,
  output calcc_pkg::calcc_coeff_t coeff,
  output calcc_pkg::calcc_config_t cfg,
  output logic signature_ok,
  output logic nvm_locked,
  output logic busy
);

  // ------------------------------------------------------------
  // Storage and state
  // ------------------------------------------------------------
  logic [7:0] img_q [0:19];
  calcc_pkg::calcc_state_t state_q;
  logic [4:0] idx_q;
  logic [7:0] crc_q;
  logic [7:0] crc_next;
  logic [159:0] shift_q;
  logic [159:0] load_vec;
  logic [4:0] sent_q;
  logic sig_ok_q;
  logic tx_valid_q;
  logic [7:0] rdata_q;
  logic [2:0] lock_field;
  logic locked;
  logic cmd_start;
  logic wr_ok;
  logic [7:0] wmask;
  logic [13:0] offset_w;
  logic [14:0] gain_w;
  logic [7:0] sot_w;

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  assign offset_w = {img_q[calcc_pkg::CALCC_OFS_HI_IDX][5:0], img_q[calcc_pkg::CALCC_OFS_LO_IDX]};
  assign sot_w = img_q[calcc_pkg::CALCC_SOT_IDX];
  assign gain_w = {img_q[calcc_pkg::CALCC_GAIN_HI_IDX], img_q[calcc_pkg::CALCC_GAIN_LO_IDX][7:1]};
  assign lock_field = {img_q[calcc_pkg::CALCC_CFG_B_IDX][1:0], img_q[calcc_pkg::CALCC_CFG_A_IDX][7]};
  assign locked = (lock_field == calcc_pkg::CALCC_LOCK_CODE_A) ||
                  (lock_field == calcc_pkg::CALCC_LOCK_CODE_B);

  assign coeff.gain = gain_w;
  assign coeff.offset = offset_w;
  assign coeff.second_order_coeff = sot_w;
  assign cfg.lock = lock_field;
  assign cfg.diag_cfg = img_q[calcc_pkg::CALCC_CFG_A_IDX][6:4];
  assign cfg.preamp_gain = img_q[calcc_pkg::CALCC_CFG_A_IDX][3:0];
  assign cfg.upper_clip = {img_q[calcc_pkg::CALCC_CFG_C_IDX][0], img_q[calcc_pkg::CALCC_CFG_B_IDX][7:2]};
  assign cfg.lower_clip = img_q[calcc_pkg::CALCC_CFG_C_IDX][7:1];
  assign cfg.adc_offset_trim = {img_q[calcc_pkg::CALCC_MODE_IDX][2:0], img_q[calcc_pkg::CALCC_TRIM_IDX][7]};
  assign cfg.reference_voltage_trim = img_q[calcc_pkg::CALCC_TRIM_IDX][6:3];
  assign cfg.osc_trim = img_q[calcc_pkg::CALCC_TRIM_IDX][2:0];
  assign cfg.regulator_config = {img_q[calcc_pkg::CALCC_GAIN_LO_IDX][0], img_q[calcc_pkg::CALCC_MODE_IDX][7]};
  assign cfg.update_rate = img_q[calcc_pkg::CALCC_MODE_IDX][6:5];
  assign cfg.output_mode = img_q[calcc_pkg::CALCC_MODE_IDX][4:3];

  // ------------------------------------------------------------
  // Request qualification
  // ------------------------------------------------------------
  assign cmd_start = (state_q == calcc_pkg::CALCC_ST_IDLE) && cmd_valid &&
                     (cmd_code == calcc_pkg::CALCC_CMD_READ);

  always_comb begin
    wmask = 8'h00;
    if (reg_addr <= calcc_pkg::CALCC_LAST_IDX) begin
      wmask = calcc_pkg::CALCC_WRITE_MASK[{reg_addr, 3'h0} +: 8];
    end
  end

  assign wr_ok = reg_wr && (state_q == calcc_pkg::CALCC_ST_IDLE) && !cmd_start &&
                 !locked && (wmask != 8'h00);

  // ------------------------------------------------------------
  // Signature step, one byte per cycle
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    logic [7:0] d;
    c = crc_q;
    d = img_q[idx_q];
    for (int b = 7; b >= 0; b--) begin
      if (c[7] ^ d[b]) begin
        c = {c[6:0], 1'b0} ^ calcc_pkg::CALCC_SIG_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_next = c;
  end

  // ------------------------------------------------------------
  // Image store
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < calcc_pkg::CALCC_NBYTES; i++) begin
        img_q[i] <= calcc_pkg::CALCC_RESET_IMAGE[i*8 +: 8];
      end
    end else begin
      if (wr_ok) begin
        img_q[reg_addr] <= reg_wdata & wmask;
      end else if ((state_q == calcc_pkg::CALCC_ST_SIGN) &&
                   (idx_q == calcc_pkg::CALCC_LAST_SIGNED_IDX)) begin
        img_q[calcc_pkg::CALCC_SIG_IDX] <= crc_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Readout image assembly
  // ------------------------------------------------------------
  always_comb begin
    load_vec = 160'h0;
    for (int i = 0; i < calcc_pkg::CALCC_NBYTES - 1; i++) begin
      load_vec[i*8 +: 8] = img_q[i];
    end
    load_vec[159:152] = calcc_pkg::CALCC_TAIL_BYTE;
  end

  // ------------------------------------------------------------
  // Control sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= calcc_pkg::CALCC_ST_CHECK;
      idx_q <= 5'h00;
      crc_q <= calcc_pkg::CALCC_SIG_SEED;
      sig_ok_q <= 1'b0;
    end else begin
      case (state_q)
        calcc_pkg::CALCC_ST_CHECK, calcc_pkg::CALCC_ST_SIGN: begin
          crc_q <= crc_next;
          if (idx_q == calcc_pkg::CALCC_LAST_SIGNED_IDX) begin
            if (state_q == calcc_pkg::CALCC_ST_CHECK) begin
              sig_ok_q <= (crc_next == img_q[calcc_pkg::CALCC_SIG_IDX]);
            end else begin
              sig_ok_q <= 1'b1;
            end
            state_q <= calcc_pkg::CALCC_ST_IDLE;
            idx_q <= 5'h00;
          end else if (idx_q == calcc_pkg::CALCC_PRE_SIG_IDX) begin
            idx_q <= calcc_pkg::CALCC_POST_SIG_IDX;
          end else begin
            idx_q <= idx_q + 5'h01;
          end
        end
        calcc_pkg::CALCC_ST_IDLE: begin
          crc_q <= calcc_pkg::CALCC_SIG_SEED;
          idx_q <= 5'h00;
          if (cmd_start) begin
            state_q <= calcc_pkg::CALCC_ST_SEND;
          end else if (wr_ok) begin
            state_q <= calcc_pkg::CALCC_ST_SIGN;
          end
        end
        calcc_pkg::CALCC_ST_SEND: begin
          if (tx_done && (sent_q == calcc_pkg::CALCC_LAST_IDX)) begin
            state_q <= calcc_pkg::CALCC_ST_IDLE;
          end
        end
        default: begin
          state_q <= calcc_pkg::CALCC_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Byte stream
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= 160'h0;
      sent_q <= 5'h00;
      tx_valid_q <= 1'b0;
    end else begin
      if (cmd_start) begin
        shift_q <= load_vec;
        sent_q <= 5'h00;
        tx_valid_q <= 1'b1;
      end else if ((state_q == calcc_pkg::CALCC_ST_SEND) && tx_done) begin
        shift_q <= {8'h00, shift_q[159:8]};
        sent_q <= sent_q + 5'h01;
        if (sent_q == calcc_pkg::CALCC_LAST_IDX) begin
          tx_valid_q <= 1'b0;
        end
      end
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_byte = shift_q[7:0];

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr < calcc_pkg::CALCC_LAST_IDX) begin
        rdata_q <= img_q[reg_addr];
      end else if (reg_addr == calcc_pkg::CALCC_LAST_IDX) begin
        rdata_q <= calcc_pkg::CALCC_TAIL_BYTE;
      end else if (reg_addr == calcc_pkg::CALCC_ADDR_STATUS) begin
        rdata_q <= {5'h00, (state_q != calcc_pkg::CALCC_ST_IDLE), locked, sig_ok_q};
      end else if (reg_addr == calcc_pkg::CALCC_ADDR_CORR_LO) begin
        rdata_q <= corr_value[7:0];
      end else if (reg_addr == calcc_pkg::CALCC_ADDR_CORR_HI) begin
        rdata_q <= {2'b00, corr_value[13:8]};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  logic locked_q;
  logic busy_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      locked_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      locked_q <= locked;
      busy_q <= (state_q != calcc_pkg::CALCC_ST_IDLE) || cmd_start || wr_ok;
    end
  end

  assign signature_ok = sig_ok_q;
  assign nvm_locked = locked_q;
  assign busy = busy_q;

  // ------------------------------------------------------------
  // Correction stage 1: offset and gain
  // ------------------------------------------------------------
  logic [13:0] diff;
  logic [30:0] prod;
  logic signed [20:0] lin_s;
  logic [13:0] lin_sat;
  logic [13:0] lin_q;
  logic lin_v_q;

  always_comb begin
    if (raw_bridge_value > offset_w) begin
      diff = raw_bridge_value - offset_w;
    end else begin
      diff = 14'h0000;
    end
  end

  always_comb begin
    prod = 31'(diff) * 31'(gain_w[13:0]);
    if (gain_w[14]) begin
      prod = prod << calcc_pkg::CALCC_GAIN_SCALE_SH;
    end
  end

  assign lin_s = $signed({1'b0, prod[30:calcc_pkg::CALCC_GAIN_FRAC]});

  calcc_sat14 #(
    .W(21)
  ) u_sat_lin (
    .value(lin_s),
    .clamped(lin_sat)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lin_q <= 14'h0000;
      lin_v_q <= 1'b0;
    end else begin
      lin_q <= lin_sat;
      lin_v_q <= raw_valid;
    end
  end

  // ------------------------------------------------------------
  // Correction stage 2: second-order term
  // ------------------------------------------------------------
  logic [27:0] bow;
  logic signed [35:0] sot_prod;
  logic signed [22:0] sum_s;
  logic [13:0] out_sat;
  logic [13:0] corr_q;
  logic corr_v_q;

  assign bow = 28'(lin_q) * 28'(calcc_pkg::CALCC_RAW_MAX - lin_q);
  assign sot_prod = $signed(sot_w) * $signed({1'b0, bow[27:14]}) *
                    $signed({1'b0, calcc_pkg::CALCC_SOT_MULT});
  assign sum_s = $signed({9'h000, lin_q}) +
                 23'(sot_prod >>> calcc_pkg::CALCC_SOT_SHIFT);

  calcc_sat14 #(
    .W(23)
  ) u_sat_out (
    .value(sum_s),
    .clamped(out_sat)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      corr_q <= 14'h0000;
      corr_v_q <= 1'b0;
    end else begin
      corr_q <= out_sat;
      corr_v_q <= lin_v_q;
    end
  end

  assign corr_value = corr_q;
  assign corr_valid = corr_v_q;

endmodule
`default_nettype wire

// ---- verification/calcc_properties.sv ----
// Purpose: Port checks on the coefficient store and image readout
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to calcc_top
`timescale 1ns/100ps
`default_nettype none
module calcc_properties (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_done,
  input wire logic raw_valid,
  input wire logic corr_valid,
  input wire calcc_pkg::calcc_coeff_t coeff,
  input wire calcc_pkg::calcc_config_t cfg,
  input wire logic nvm_locked,
  input wire logic busy
);
  logic [4:0] sent_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // Bytes acknowledged in the current stream
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sent_q <= 5'h00;
    end else if (!tx_valid) begin
      sent_q <= 5'h00;
    end else if (tx_done) begin
      sent_q <= sent_q + 5'h01;
    end
  end
  sequence start_seq;
    cmd_valid && cmd_code == 8'h00 && !busy && !tx_valid;
  endsequence
  sequence last_ack_seq;
    tx_valid && tx_done && sent_q == 5'h13;
  endsequence
  sequence wr_ok_seq;
    reg_wr && reg_addr == 5'h00 && !busy && !tx_valid && !nvm_locked && !cmd_valid;
  endsequence
  cmd_start_a: assert property (start_seq |=> tx_valid)
    else $error("read command did not start a stream");
  bad_cmd_a: assert property ((cmd_valid && cmd_code != 8'h00 && !tx_valid) |=> !tx_valid)
    else $error("other command started a stream");
  byte_hold_a: assert property ((tx_valid && !tx_done) |=> $stable(tx_byte))
    else $error("byte changed without acknowledge");
  byte_count_a: assert property ((tx_valid && tx_done && sent_q < 5'h13) |=> tx_valid)
    else $error("stream ended early");
  stream_end_a: assert property (last_ack_seq |=> !tx_valid)
    else $error("stream longer than twenty bytes");
  tail_byte_a: assert property ((tx_valid && sent_q == 5'h13) |-> tx_byte == calcc_pkg::CALCC_TAIL_BYTE)
    else $error("last byte not the constant");
  ofs_map_a: assert property ((reg_rd && reg_addr == 5'h01) |=> reg_rdata == {2'b00, $past(coeff.offset[13:8])})
    else $error("offset high byte mismatch");
  gain_map_a: assert property ((reg_rd && reg_addr == 5'h12) |=> reg_rdata == $past(coeff.gain[14:7]))
    else $error("gain high byte mismatch");
  cfg_map_a: assert property ((reg_rd && reg_addr == 5'h08) |=>
    reg_rdata == {$past(cfg.lock[0]), $past(cfg.diag_cfg), $past(cfg.preamp_gain)})
    else $error("config byte mismatch");
  rsvd_zero_a: assert property ((reg_rd && reg_addr inside {[5'h02:5'h06]}) |=> reg_rdata == 8'h00)
    else $error("reserved byte not zero");
  corr_lat_a: assert property (raw_valid |-> ##2 corr_valid)
    else $error("corrected value late");
  lock_flag_a: assert property ((cfg.lock == 3'h3 || cfg.lock == 3'h6) |=> nvm_locked)
    else $error("lock code not reported");
  lock_hold_a: assert property ((nvm_locked && reg_wr) |=> $stable(coeff) && $stable(cfg))
    else $error("locked image changed");
  sign_busy_a: assert property (wr_ok_seq |-> ##[1:2] busy)
    else $error("no signature pass after write");
  stream_c: cover property (last_ack_seq);
endmodule
bind calcc_top calcc_properties u_props (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .tx_done(tx_done), .raw_valid(raw_valid), .corr_valid(corr_valid), .coeff(coeff),
  .cfg(cfg), .nvm_locked(nvm_locked), .busy(busy));
`default_nettype wire

// ---- verification/calcc_host_model.sv ----
// Purpose: Link host that commands a readout and acknowledges each byte
// Assumes: Acknowledge is a one-cycle pulse
// Notes: Received bytes kept in rx, count in n_rx
`timescale 1ns/100ps
`default_nettype none
module calcc_host_model (
  input wire logic mclk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic tx_done
);
  logic [7:0] rx [0:19];
  int n_rx;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'hFF;
    tx_done = 1'b0;
    n_rx = 0;
  end
  task automatic read_image(input logic [7:0] code, input int gap, input int nbytes);
    int k;
    int i;
    n_rx = 0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    #1;
    for (k = 0; k < 8 && tx_valid !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    for (i = 0; i < nbytes; i++) begin
      repeat (gap) @(posedge mclk);
      #1;
      if (tx_valid !== 1'b1) break;
      rx[i] = tx_byte;
      n_rx++;
      @(posedge mclk);
      tx_done <= 1'b1;
      @(posedge mclk);
      tx_done <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the coefficient store and readout
// Assumes: Register port reads answer one cycle later
// Notes: Expected image kept in img
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk, arst_n, reg_wr, reg_rd, cmd_valid, tx_done, tx_valid, raw_valid, corr_valid, busy, nvm_locked, sig_ok;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cmd_code, tx_byte;
  logic [13:0] raw_bridge_value, corr_value;
  calcc_pkg::calcc_coeff_t coeff;
  calcc_pkg::calcc_config_t cfg;
  logic [7:0] img [0:19];
  logic [12:0] wtab [0:9] = '{13'h01FF, 13'h0034, 13'h0710, 13'h0FC8, 13'h1035, 13'h11AB, 13'h1293, 13'h0B11,
    13'h0C22, 13'h0D33};
  logic [2:0] codes [0:2] = '{3'h1, 3'h3, 3'h6};
  int err_total = 0, num_checks = 0, cyc = 0, i;
  calcc_top DUT (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_done(tx_done), .raw_valid(raw_valid), .raw_bridge_value(raw_bridge_value),
    .corr_valid(corr_valid), .corr_value(corr_value), .coeff(coeff), .cfg(cfg), .signature_ok(sig_ok),
    .nvm_locked(nvm_locked), .busy(busy));
  calcc_host_model host (.mclk(mclk), .tx_valid(tx_valid), .tx_byte(tx_byte), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .tx_done(tx_done));
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic idle;
    int k;
    repeat (3) @(posedge mclk);
    #1;
    for (k = 0; k < 40 && busy !== 1'b0; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("busy", 24'(busy), 24'h0);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("read data", 24'(reg_rdata), 24'(e));
  endtask
  task automatic reset_dut;
    arst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk("busy in reset", 24'(busy), 24'h1);
    @(posedge mclk);
    arst_n <= 1'b1;
    for (i = 0; i < 20; i++) img[i] = 8'h00;
    img[8] = 8'h71;
    img[9] = 8'hFC;
    img[10] = 8'h01;
    idle();
    chk("signature ok", 24'(sig_ok), 24'(crc8() == 8'h00));
  endtask
  function automatic logic [7:0] crc8;
    logic [7:0] c;
    c = 8'h00;
    for (int n = 0; n < 19; n++)
      if (n != 14)
        for (int b = 7; b >= 0; b--) c = {c[6:0], 1'b0} ^ ((c[7] ^ img[n][b]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [13:0] corr_exp(input logic [13:0] raw);
    longint ofs, g, y, t;
    ofs = {img[1][5:0], img[0]};
    g = {img[18], img[17][7:1]};
    y = (raw > ofs) ? raw - ofs : 0;
    y = (y * g[13:0] * (g[14] ? 8 : 1)) >> 11;
    if (y > 16383) y = 16383;
    t = (longint'($signed(img[7])) * ((y * (16383 - y)) >> 14) * 41) >>> 14;
    y = y + t;
    y = (y < 0) ? 0 : ((y > 16383) ? 16383 : y);
    return y[13:0];
  endfunction
  task automatic stream(input int gap);
    host.read_image(8'h00, gap, 20);
    #1 chk("valid after last", 24'(tx_valid), 24'h0);
    chk("byte count", 24'(host.n_rx), 24'd20);
    for (i = 0; i < 20; i++)
      chk("stream byte", 24'(host.rx[i]), 24'(i == 14 ? crc8() : (i == 19 ? 8'hA5 : img[i])));
  endtask
  task automatic rawc(input logic [13:0] v);
    @(posedge mclk);
    raw_valid <= 1'b1;
    raw_bridge_value <= v;
    @(posedge mclk);
    raw_valid <= 1'b0;
    @(posedge mclk);
    #1 chk("corr valid", 24'(corr_valid), 24'h1);
    chk("corr value", 24'(corr_value), 24'(corr_exp(v)));
    rdc(5'h15, 8'(corr_exp(v)));
    rdc(5'h16, 8'(corr_exp(v) >> 8));
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, raw_valid, arst_n} = 4'h0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    raw_bridge_value = 14'h0000;
    reset_dut();
    for (i = 0; i < 14; i++) rdc(5'(i), img[i]);
    chk("clip and gain", 24'({cfg.upper_clip, cfg.lower_clip, cfg.preamp_gain}), 24'h3F801);
    $display("test defaults done");
    for (i = 0; i < 10; i++) begin
      wr(wtab[i][12:8], wtab[i][7:0]);
      idle();
      img[wtab[i][12:8]] = wtab[i][7:0] & (wtab[i][12:8] == 5'h01 ? 8'h3F : 8'hFF);
    end
    wr(5'h03, 8'hFF);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= 5'h0C;
    reg_wdata <= 8'h55;
    @(posedge mclk);
    reg_wdata <= 8'h77;
    @(posedge mclk);
    reg_wr <= 1'b0;
    idle();
    img[12] = 8'h55;
    chk("offset", 24'(coeff.offset), 24'h3F34);
    chk("gain", 24'(coeff.gain), 24'h49D5);
    chk("second order", 24'(coeff.second_order_coeff), 24'h10);
    chk("trims", 24'({cfg.adc_offset_trim, cfg.reference_voltage_trim, cfg.osc_trim, cfg.regulator_config,
      cfg.update_rate, cfg.output_mode}), 24'h17226);
    for (i = 0; i < 19; i++) if (i != 14) rdc(5'(i), img[i]);
    $display("test coefficients done");
    stream(0);
    host.read_image(8'h01, 0, 20);
    chk("other command", 24'(host.n_rx), 24'h0);
    stream(3);
    $display("test readout done");
    rawc(14'h0000);
    rawc(14'h3FFF);
    rawc(14'h3F40);
    $display("test correction done");
    for (int c = 0; c < 3; c++) begin
      reset_dut();
      wr(5'h09, {6'h3F, codes[c][2:1]});
      idle();
      wr(5'h08, {codes[c][0], 7'h71});
      idle();
      chk("locked", 24'(nvm_locked), 24'(codes[c] != 3'h1));
      wr(5'h00, 8'h5A);
      idle();
      rdc(5'h00, codes[c] == 3'h1 ? 8'h5A : 8'h00);
      rdc(5'h14, {6'h00, codes[c] != 3'h1, 1'b1});
    end
    $display("test lock done");
    conclude();
  end
endmodule
`default_nettype wire
